// file: uff_consts.svh
/*
 * Offsets, field positions, reset values and trigger levels of the FIFO and
 * flow-control block. Assumes byte addressing on APB, one 32-bit word per register.
 */
// Contract
// - Receive trigger select: 8, 16, 56, 60.
// - Transmit trigger select: 8, 16, 32, 56 spaces.
// - Transmit trigger writes need enhanced gate bit.
// - Transmit flush empties FIFO, self-clears.
// - Receive flush empties FIFO, self-clears.
// - FIFO disabled: one character, trigger one.
// - FIFO enabled: 64 characters each way.
// - FIFO control writable when divisor select clear.
// - Enhanced register needs 0xBF and special bit clear.
// - Enhanced bit 7 enables automatic CTS.
// - Enhanced bit 6 enables automatic RTS.
// - Special detect stores second pause, flags it.
// - Flow-compared second pause: dropped, both flags.
// - Enhanced bit 4 gates enhanced field writes.
// - Bits 3:2 pick transmitted flow characters.
// - Bits 1:0 pick compared flow characters.
// - Codes 1011, 0111 accept either character.
// - Codes 1111, 0011 need both characters.
// - Automatic RTS overrides software RTS bit.
`ifndef UFF_CONSTS_SVH
`define UFF_CONSTS_SVH

// ---------------------------------------------------------------------------
// Register indexes; byte address is four times the index.
// ---------------------------------------------------------------------------
`define UFF_IDX_DATA      4'h0
`define UFF_IDX_IER       4'h1
`define UFF_IDX_FCR       4'h2
`define UFF_IDX_LCR       4'h3
`define UFF_IDX_MCR       4'h4
`define UFF_IDX_XCHR_LAST 4'h7
`define UFF_IDX_SFR       4'h8
`define UFF_IDX_LEVEL     4'h9
`define UFF_ENH_KEY       8'hbf

// ---------------------------------------------------------------------------
// Field positions.
// ---------------------------------------------------------------------------
`define UFF_FCR_EN        0
`define UFF_FCR_RXRST     1
`define UFF_FCR_TXRST     2
`define UFF_LCR_DLAB      7
`define UFF_SFR_NOENH     2
`define UFF_EFR_CTS       7
`define UFF_EFR_RTS       6
`define UFF_EFR_SPECIAL   5
`define UFF_EFR_GATE      4
`define UFF_MCR_XONANY    5
`define UFF_MCR_RTS       1

// ---------------------------------------------------------------------------
// Reset values and depths.
// ---------------------------------------------------------------------------
`define UFF_RST_BYTE      8'h00
`define UFF_DEPTH         7'd64
`define UFF_SINGLE        7'd1
`define UFF_RX_TRIG0      7'd8
`define UFF_RX_TRIG1      7'd16
`define UFF_RX_TRIG2      7'd56
`define UFF_RX_TRIG3      7'd60
`define UFF_TX_TRIG0      7'd8
`define UFF_TX_TRIG1      7'd16
`define UFF_TX_TRIG2      7'd32
`define UFF_TX_TRIG3      7'd56

`endif

// file: uff_pkg.sv
/*
 * Types shared by the FIFO and flow-control block.
 * Assumes nothing of its surroundings.
 */
package uff_pkg;

  // One character on the byte stream to or from the shift registers.
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } uff_char_t;

  typedef enum logic [1:0] {
    FL_IDLE   = 2'b00,
    FL_FIRST  = 2'b01,
    FL_SECOND = 2'b10
  } uff_flow_state_t;

endpackage

// file: uff_fifo_flow.sv
/*
 * Transmit and receive FIFOs, trigger levels and RTS/CTS and pause/resume flow
 * control of a UART, with an APB register slave. Assumes the shift registers sit
 * outside: they hand in received bytes and take bytes to send one at a time.
 */
`include "uff_consts.svh"

module uff_fifo_flow (
  input  wire logic              core_clk_in,   // Block clock, 250 MHz.
  input  wire logic              nrst_in,       // Asynchronous reset, active low.
  input  wire logic              psel_in,       // APB select.
  input  wire logic              penable_in,    // APB enable.
  input  wire logic              pwrite_in,     // APB direction, high for write.
  input  wire logic [7:0]        paddr_in,      // APB byte address.
  input  wire logic [31:0]       pwdata_in,     // APB write data.
  output logic      [31:0]       prdata_out,    // APB read data.
  output logic                   pready_out,    // APB ready.
  output logic                   pslverr_out,   // APB error on unmapped address.
  input  wire uff_pkg::uff_char_t rx_char_in,   // Byte from receive shift register.
  output uff_pkg::uff_char_t     tx_char_out,   // Byte offered to transmit shifter.
  input  wire logic              tx_ready_in,   // Transmit shifter takes the byte.
  input  wire logic              cts_n_in,      // Clear to send, active low.
  output logic                   rts_n_out,     // Request to send, active low.
  output logic                   rx_trig_out,   // Receive fill reached trigger.
  output logic                   tx_trig_out    // Transmit space reached trigger.
);
  import uff_pkg::*;

  // -------------------------------------------------------------------------
  // Registers.
  // -------------------------------------------------------------------------
  logic            fcr_en_ff;
  logic [1:0]      rx_sel_ff;
  logic [1:0]      tx_sel_ff;
  logic [7:0]      efr_ff;
  logic [7:0]      lcr_ff;
  logic [7:0]      mcr_ff;
  logic [7:0]      ier_ff;
  logic [7:0]      sfr_ff;
  logic [7:0]      xchr_ff [4];   // Resume first, resume second, pause first, pause second.
  logic            paused_ff;
  logic            special_ff;
  logic            xoff_int_ff;
  logic            seen_on_ff;
  logic            seen_off_ff;
  logic            hold_vld_ff;
  logic            hold_flow_ff;
  logic [7:0]      hold_dat_ff;
  logic            sent_off_ff;
  logic            rts_n_ff;
  logic            rx_trig_ff;
  logic            tx_trig_ff;
  logic [31:0]     prdata_ff;
  uff_flow_state_t fl_state_ff;
  uff_flow_state_t nxt_fl_state;

  // -------------------------------------------------------------------------
  // APB decode.
  // -------------------------------------------------------------------------
  wire logic [3:0] idx      = paddr_in[5:2];
  wire logic       mapped   = (paddr_in[1:0] == 2'b00) && (paddr_in[7:6] == 2'b00)
                              && (idx <= `UFF_IDX_LEVEL);
  wire logic       setup    = psel_in & ~penable_in;
  wire logic       acc      = psel_in & penable_in & mapped;
  wire logic       wr       = acc & pwrite_in;
  wire logic       rd       = acc & ~pwrite_in;
  wire logic       dlab     = lcr_ff[`UFF_LCR_DLAB];
  wire logic       efr_sel  = (lcr_ff == `UFF_ENH_KEY) && !sfr_ff[`UFF_SFR_NOENH];
  wire logic       gate     = efr_ff[`UFF_EFR_GATE];
  wire logic       xchr_sel = efr_sel && (idx >= `UFF_IDX_MCR) && (idx <= `UFF_IDX_XCHR_LAST);
  wire logic [1:0] xchr_idx = 2'(idx - `UFF_IDX_MCR);
  wire logic       wr_thr   = wr && (idx == `UFF_IDX_DATA) && !dlab;
  wire logic       rd_rhr   = rd && (idx == `UFF_IDX_DATA) && !dlab;
  wire logic       wr_efr   = wr && (idx == `UFF_IDX_FCR) && efr_sel;
  wire logic       wr_fcr   = wr && (idx == `UFF_IDX_FCR) && !dlab;
  wire logic       rd_iir   = rd && (idx == `UFF_IDX_FCR) && !dlab;
  wire logic       fcr_on   = pwdata_in[`UFF_FCR_EN];

  // Toggling the FIFO mode flushes both sides so stale levels never leak across.
  wire logic       flush_tx = wr_fcr && (fcr_on ? (pwdata_in[`UFF_FCR_TXRST] || !fcr_en_ff)
                                                 : fcr_en_ff);
  wire logic       flush_rx = wr_fcr && (fcr_on ? (pwdata_in[`UFF_FCR_RXRST] || !fcr_en_ff)
                                                 : fcr_en_ff);

  // -------------------------------------------------------------------------
  // The two FIFOs: entry 0 transmit, entry 1 receive.
  // -------------------------------------------------------------------------
  logic [6:0] cnt  [2];
  logic [7:0] head [2];
  logic       push [2];
  logic       pop  [2];
  logic       flush[2];
  logic [7:0] din  [2];
  // With the FIFOs off each side holds one character and triggers at one.
  wire logic [6:0] cap = fcr_en_ff ? `UFF_DEPTH : `UFF_SINGLE;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_fifo
      // Storage has no reset: the count alone says which entries hold data.
      logic [7:0] mem [64];
      logic [5:0] wptr_ff;
      logic [5:0] rptr_ff;
      logic [6:0] cnt_ff;
      wire  logic do_push = push[g] && (cnt_ff < cap);
      wire  logic do_pop  = pop[g] && (cnt_ff != 7'd0);
      assign cnt[g]  = cnt_ff;
      assign head[g] = mem[rptr_ff];
      always_ff @(posedge core_clk_in) begin
        if (do_push && !flush[g]) begin
          mem[wptr_ff] <= din[g];
        end
      end
      always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
          wptr_ff <= 6'h00;
          rptr_ff <= 6'h00;
          cnt_ff  <= 7'h00;
        end else if (flush[g]) begin
          wptr_ff <= 6'h00;
          rptr_ff <= 6'h00;
          cnt_ff  <= 7'h00;
        end else begin
          wptr_ff <= wptr_ff + 6'(do_push);
          rptr_ff <= rptr_ff + 6'(do_pop);
          cnt_ff  <= cnt_ff + 7'(do_push) - 7'(do_pop);
        end
      end
    end
  endgenerate

  // -------------------------------------------------------------------------
  // Trigger levels.
  // -------------------------------------------------------------------------
  wire logic [6:0] rx_lvl = (rx_sel_ff == 2'b00) ? `UFF_RX_TRIG0 :
                            (rx_sel_ff == 2'b01) ? `UFF_RX_TRIG1 :
                            (rx_sel_ff == 2'b10) ? `UFF_RX_TRIG2 : `UFF_RX_TRIG3;
  wire logic [6:0] tx_lvl = (tx_sel_ff == 2'b00) ? `UFF_TX_TRIG0 :
                            (tx_sel_ff == 2'b01) ? `UFF_TX_TRIG1 :
                            (tx_sel_ff == 2'b10) ? `UFF_TX_TRIG2 : `UFF_TX_TRIG3;
  wire logic [6:0] rx_trg = fcr_en_ff ? rx_lvl : `UFF_SINGLE;
  wire logic [6:0] tx_trg = fcr_en_ff ? tx_lvl : `UFF_SINGLE;

  wire logic [6:0] tx_free = cap - cnt[0];
  wire logic       rx_met  = cnt[1] >= rx_trg;
  wire logic       tx_met  = tx_free >= tx_trg;

  // -------------------------------------------------------------------------
  // Receive side: flow character matching.
  // -------------------------------------------------------------------------
  wire logic [1:0] rxm    = efr_ff[1:0];
  wire logic [1:0] txm    = efr_ff[3:2];
  wire logic       rvld   = rx_char_in.valid;
  wire logic [7:0] rch    = rx_char_in.data;
  wire logic       is_on1 = rch == xchr_ff[0];
  wire logic       is_on2 = rch == xchr_ff[1];
  wire logic       is_of1 = rch == xchr_ff[2];
  wire logic       is_of2 = rch == xchr_ff[3];
  // Codes 1011 and 0111 take either character; 1111 and 0011 need the pair in order.
  wire logic       either = (rxm == 2'b11) && (txm == 2'b10 || txm == 2'b01);
  wire logic       dbl    = (rxm == 2'b11) && !either;
  wire logic       m_on   = rvld && (((rxm == 2'b10) && is_on1) || ((rxm == 2'b01) && is_on2)
                            || (either && (is_on1 || is_on2))
                            || (dbl && seen_on_ff && is_on2));
  wire logic       m_off  = rvld && (((rxm == 2'b10) && is_of1) || ((rxm == 2'b01) && is_of2)
                            || (either && (is_of1 || is_of2))
                            || (dbl && seen_off_ff && is_of2));
  wire logic       m_spec = rvld && efr_ff[`UFF_EFR_SPECIAL] && is_of2;
  // Resume-on-any reopens the transmitter on any received byte except a pause.
  wire logic       xonany = rvld && mcr_ff[`UFF_MCR_XONANY];

  assign push[1]  = rvld && !m_on && !m_off;
  assign din[1]   = rch;
  assign pop[1]   = rd_rhr;
  assign flush[1] = flush_rx;

  // -------------------------------------------------------------------------
  // Transmit side: holding stage, flow characters and CTS gating.
  // -------------------------------------------------------------------------
  wire logic       cts_blk  = efr_ff[`UFF_EFR_CTS] && cts_n_in;
  wire logic       tx_vld   = hold_vld_ff && !cts_blk && (hold_flow_ff || !paused_ff);
  // A byte already taken by the shifter always finishes; CTS only stops the next offer.
  wire logic       tx_take  = tx_vld && tx_ready_in;
  wire logic       hold_fr  = !hold_vld_ff || tx_take;
  wire logic       fl_load  = (fl_state_ff != FL_IDLE) && hold_fr;
  wire logic       fl_start = (fl_state_ff == FL_IDLE) && (txm != 2'b00)
                              && (rx_met != sent_off_ff);
  wire logic       dt_load  = (fl_state_ff == FL_IDLE) && hold_fr && (cnt[0] != 7'd0)
                              && !paused_ff && !cts_blk;
  wire logic [1:0] fl_pick  = {sent_off_ff, fl_state_ff == FL_SECOND};
  wire logic [7:0] fl_char  = xchr_ff[fl_pick];

  assign push[0]  = wr_thr;
  assign din[0]   = pwdata_in[7:0];
  assign pop[0]   = dt_load;
  assign flush[0] = flush_tx;
  assign tx_char_out = '{valid: tx_vld, data: hold_dat_ff};

  always_comb begin
    nxt_fl_state = fl_state_ff;
    case (fl_state_ff)
      FL_IDLE: begin
        if (fl_start) begin
          nxt_fl_state = txm[1] ? FL_FIRST : FL_SECOND;
        end
      end
      FL_FIRST: begin
        if (fl_load) begin
          nxt_fl_state = txm[0] ? FL_SECOND : FL_IDLE;
        end
      end
      FL_SECOND: begin
        if (fl_load) begin
          nxt_fl_state = FL_IDLE;
        end
      end
      default: begin
        nxt_fl_state = FL_IDLE;
      end
    endcase
  end

  // -------------------------------------------------------------------------
  // Read data, prepared in the setup cycle so the access phase needs no wait.
  // -------------------------------------------------------------------------
  wire logic       int_pend = special_ff || xoff_int_ff;
  wire logic [7:0] iir_val  = {{2{fcr_en_ff}}, 1'b0, int_pend, 3'b000, !int_pend};
  wire logic [31:0] level_val = {9'h000, cnt[1], 5'h00, rx_met, tx_met, paused_ff,
                                 1'b0, cnt[0]};
  // Unmapped or misaligned reads still load this word; only the error flag marks them.
  logic [31:0] rd_val;
  always_comb begin
    rd_val = 32'h0000_0000;
    if (idx == `UFF_IDX_DATA) begin
      rd_val = dlab ? 32'h0000_0000 : {24'h000000, head[1]};
    end else if (idx == `UFF_IDX_IER) begin
      rd_val = dlab ? 32'h0000_0000 : {24'h000000, ier_ff};
    end else if (idx == `UFF_IDX_FCR) begin
      rd_val = efr_sel ? {24'h000000, efr_ff} : dlab ? 32'h0000_0000 : {24'h000000, iir_val};
    end else if (idx == `UFF_IDX_LCR) begin
      rd_val = {24'h000000, lcr_ff};
    end else if (xchr_sel) begin
      rd_val = {24'h000000, xchr_ff[xchr_idx]};
    end else if ((idx == `UFF_IDX_MCR) && !dlab) begin
      rd_val = {24'h000000, mcr_ff};
    end else if (idx == `UFF_IDX_SFR) begin
      rd_val = {24'h000000, sfr_ff};
    end else if (idx == `UFF_IDX_LEVEL) begin
      rd_val = level_val;
    end
  end

  // Zero wait states: every register is ready in the access phase.
  assign prdata_out  = prdata_ff;
  assign pready_out  = 1'b1;
  assign pslverr_out = psel_in && penable_in && !mapped;
  assign rts_n_out   = rts_n_ff;
  assign rx_trig_out = rx_trig_ff;
  assign tx_trig_out = tx_trig_ff;

  // -------------------------------------------------------------------------
  // Control and configuration registers.
  // -------------------------------------------------------------------------
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      fcr_en_ff <= 1'b0;
      rx_sel_ff <= 2'b00;
      tx_sel_ff <= 2'b00;
      efr_ff    <= `UFF_RST_BYTE;
      lcr_ff    <= `UFF_RST_BYTE;
      mcr_ff    <= `UFF_RST_BYTE;
      ier_ff    <= `UFF_RST_BYTE;
      sfr_ff    <= `UFF_RST_BYTE;
      for (int i = 0; i < 4; i++) begin
        xchr_ff[i] <= `UFF_RST_BYTE;
      end
    end else if (wr) begin
      if (wr_efr) begin
        efr_ff <= pwdata_in[7:0];
      end else if (wr_fcr) begin
        fcr_en_ff <= fcr_on;
        if (fcr_on) begin
          rx_sel_ff <= pwdata_in[7:6];
          if (gate) begin
            tx_sel_ff <= pwdata_in[5:4];
          end
        end
      end
      if ((idx == `UFF_IDX_IER) && !dlab) begin
        ier_ff <= {gate ? pwdata_in[7:4] : ier_ff[7:4], pwdata_in[3:0]};
      end
      if (idx == `UFF_IDX_LCR) begin
        lcr_ff <= pwdata_in[7:0];
      end
      if (xchr_sel) begin
        xchr_ff[xchr_idx] <= pwdata_in[7:0];
      end else if ((idx == `UFF_IDX_MCR) && !dlab) begin
        mcr_ff <= {gate ? pwdata_in[7:5] : mcr_ff[7:5], pwdata_in[4:0]};
      end
      if (idx == `UFF_IDX_SFR) begin
        sfr_ff <= pwdata_in[7:0];
      end
    end
  end

  // -------------------------------------------------------------------------
  // Flow state, flags and the transmit holding stage.
  // -------------------------------------------------------------------------
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      paused_ff    <= 1'b0;
      special_ff   <= 1'b0;
      xoff_int_ff  <= 1'b0;
      seen_on_ff   <= 1'b0;
      seen_off_ff  <= 1'b0;
      sent_off_ff  <= 1'b0;
      fl_state_ff  <= FL_IDLE;
      hold_vld_ff  <= 1'b0;
      hold_flow_ff <= 1'b0;
      hold_dat_ff  <= `UFF_RST_BYTE;
    end else begin
      // A pause wins over a resume-by-any-character arriving with it.
      if (m_off) begin
        paused_ff <= 1'b1;
      end else if (m_on || xonany) begin
        paused_ff <= 1'b0;
      end
      // Flags set in the cycle of the clearing read stay set.
      special_ff  <= m_spec || (special_ff && !rd_iir);
      xoff_int_ff <= m_off || (xoff_int_ff && !rd_iir);
      if (rvld) begin
        seen_on_ff  <= dbl && is_on1;
        seen_off_ff <= dbl && is_of1;
      end
      if (fl_start) begin
        sent_off_ff <= rx_met;
      end
      fl_state_ff <= nxt_fl_state;
      if (fl_load) begin
        hold_vld_ff  <= 1'b1;
        hold_flow_ff <= 1'b1;
        hold_dat_ff  <= fl_char;
      end else if (dt_load) begin
        hold_vld_ff  <= 1'b1;
        hold_flow_ff <= 1'b0;
        hold_dat_ff  <= head[0];
      end else if (tx_take) begin
        hold_vld_ff <= 1'b0;
      end
    end
  end

  // -------------------------------------------------------------------------
  // Registered outputs and read data.
  // -------------------------------------------------------------------------
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rts_n_ff   <= 1'b1;
      rx_trig_ff <= 1'b0;
      tx_trig_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end else begin
      rts_n_ff   <= efr_ff[`UFF_EFR_RTS] ? rx_met : !mcr_ff[`UFF_MCR_RTS];
      rx_trig_ff <= rx_met;
      tx_trig_ff <= tx_met;
      if (setup) begin
        prdata_ff <= rd_val;
      end
    end
  end

endmodule

// file: uff_fifo_flow_monitor.sv
/*
 * Port-level assertions for the FIFO and flow-control block.
 * Assumes it is bound to uff_fifo_flow and that software leaves the special bit clear.
 */
module uff_fifo_flow_monitor
  import uff_pkg::*;
(
  input wire logic              core_clk_in,  // Block clock.
  input wire logic              nrst_in,      // Reset, active low.
  input wire logic              psel_in,      // APB select.
  input wire logic              penable_in,   // APB enable.
  input wire logic              pwrite_in,    // APB direction.
  input wire logic [7:0]        paddr_in,     // APB address.
  input wire logic [31:0]       pwdata_in,    // APB write data.
  input wire logic [31:0]       prdata_out,   // APB read data.
  input wire logic              pready_out,   // APB ready.
  input wire logic              pslverr_out,  // APB error.
  input wire uff_pkg::uff_char_t rx_char_in,  // Received byte.
  input wire uff_pkg::uff_char_t tx_char_out, // Offered byte.
  input wire logic              tx_ready_in,  // Shifter takes byte.
  input wire logic              cts_n_in,     // Clear to send.
  input wire logic              rts_n_out,    // Request to send.
  input wire logic              rx_trig_out,  // Receive trigger.
  input wire logic              tx_trig_out   // Transmit trigger.
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] lcr_ff;
  logic [7:0] efr_ff;
  logic       mcr1_ff;
  wire        wr_acc = psel_in && penable_in && pwrite_in;
  wire  [3:0] idx    = paddr_in[5:2];
  wire        bad    = idx > 4'h9 || paddr_in[1:0] != 2'h0 || paddr_in[7:6] != 2'h0;
  wire        fcr_wr = wr_acc && !bad && idx == 4'h2 && !lcr_ff[7] && pwdata_in[0];

  // The mirrors only follow fields whose write rules are unconditional enough to copy.
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      lcr_ff <= 8'h00;
      efr_ff <= 8'h00;
      mcr1_ff <= 1'b0;
    end else if (wr_acc && !bad) begin
      if (idx == 4'h3) lcr_ff <= pwdata_in[7:0];
      if (idx == 4'h2 && lcr_ff == 8'hbf) efr_ff <= pwdata_in[7:0];
      if (idx == 4'h4 && !lcr_ff[7]) mcr1_ff <= pwdata_in[1];
    end
  end

  default clocking mon_cb @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);

  property p_rts_sw; !efr_ff[6] && !wr_acc |=> rts_n_out == !mcr1_ff; endproperty
  a_rts_sw: assert property (p_rts_sw) else $error("rts_n differs from software bit");
  property p_rts_auto; efr_ff[6] && $past(efr_ff[6]) |-> rts_n_out == rx_trig_out; endproperty
  a_rts_auto: assert property (p_rts_auto) else $error("rts_n differs from fill");
  property p_cts_block;
    (efr_ff[7] && efr_ff[3:2] == 2'b00 && cts_n_in) [*3] |-> !tx_char_out.valid;
  endproperty
  a_cts_block: assert property (p_cts_block) else $error("byte offered without cts");
  property p_tx_hold;
    tx_char_out.valid && !tx_ready_in && efr_ff[3:2] == 2'b00
      |=> !tx_char_out.valid || $stable(tx_char_out.data);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("offered byte changed");
  property p_err_map; psel_in && penable_in && bad |-> pslverr_out; endproperty
  a_err_map: assert property (p_err_map) else $error("no error on unmapped access");
  property p_err_phase; pslverr_out |-> psel_in && penable_in && bad; endproperty
  a_err_phase: assert property (p_err_phase) else $error("stray error");
  property p_tx_flush; fcr_wr && pwdata_in[2] |-> ##2 tx_trig_out; endproperty
  a_tx_flush: assert property (p_tx_flush) else $error("tx flush left data");
  property p_rx_flush; fcr_wr && pwdata_in[1] |-> ##2 !rx_trig_out; endproperty
  a_rx_flush: assert property (p_rx_flush) else $error("rx flush left data");
endmodule

bind uff_fifo_flow uff_fifo_flow_monitor mon (.*);

// file: uff_peer_model.sv
/*
 * Byte-side peer: a shifter that takes bytes, a receiver that hands bytes in, and CTS.
 * Assumes the bench steers stalls and clear-to-send through its inputs.
 */
module uff_peer_model
  import uff_pkg::*;
(
  input  wire logic               clk_in,       // Block clock.
  input  wire logic               slow_in,      // Take a byte every other cycle only.
  input  wire logic               hold_in,      // Keep clear-to-send inactive.
  input  wire uff_pkg::uff_char_t tx_char_in,   // Byte offered by the block.
  output logic                    tx_ready_out, // Shifter takes the byte.
  output logic                    cts_n_out,    // Clear to send, active low.
  output uff_pkg::uff_char_t      rx_char_out   // One-cycle pulse per byte.
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    tx_ready_out = 1'b1;
    cts_n_out = 1'b0;
    rx_char_out = '{valid: 1'b0, data: 8'h00};
  end
  always @(posedge clk_in) begin
    tx_ready_out <= slow_in ? !tx_ready_out : 1'b1;
    cts_n_out <= hold_in;
  end
  task automatic send(input logic [7:0] b);
    @(posedge clk_in);
    rx_char_out <= '{valid: 1'b1, data: b};
    @(posedge clk_in);
    // Idle data shows the inverse so a stale copy can never pass as fresh.
    rx_char_out <= '{valid: 1'b0, data: ~b};
  endtask
endmodule

// file: uff_fifo_flow_test.sv
/*
 * Self-checking bench for the FIFO and flow-control block.
 * Assumes the peer model and the bound checker are compiled with it.
 */
module uff_fifo_flow_test;
  timeunit 1ns;
  timeprecision 1ps;
  import uff_pkg::*;
  logic        clk = 1'b0, nrst = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic        slow = 1'b0, hold = 1'b0, pready, pslverr, tx_ready, cts_n, rts_n, rxt, txt;
  logic [7:0]  paddr = 8'h00, b;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [32:0] exp_q[$], txe_q[$];
  uff_char_t   rx_c, tx_c;
  int          fail_count = 0, checked = 0, seed = 54, n, rxl[4] = '{8, 16, 56, 60};
  always #2 clk = ~clk;
  uff_fifo_flow DUT (
    .core_clk_in(clk), .nrst_in(nrst), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
    .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .rx_char_in(rx_c), .tx_char_out(tx_c), .tx_ready_in(tx_ready),
    .cts_n_in(cts_n), .rts_n_out(rts_n), .rx_trig_out(rxt), .tx_trig_out(txt));
  uff_peer_model peer (.clk_in(clk), .slow_in(slow), .hold_in(hold), .tx_char_in(tx_c),
    .tx_ready_out(tx_ready), .cts_n_out(cts_n), .rx_char_out(rx_c));
  task automatic chk(input string nm, input logic [32:0] ex, input logic [32:0] got);
    checked++;
    if (got !== ex) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", nm, ex, got);
    end
  endtask
  task automatic final_report;
    $display("checks %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic give_up;
    fail_count++;
    final_report;
  endtask
  // Every access leaves a note; the watcher below settles it at the access edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [32:0] ex);
    exp_q.push_back(ex);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (n == 20) give_up;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d}, 33'h0);
  endtask
  task automatic enh(input logic [7:0] a, input logic [7:0] d);
    wr(8'h0c, 8'hbf);
    wr(a, d);
    wr(8'h0c, 8'h00);
  endtask
  task automatic drain;
    for (n = 0; n < 300; n++) begin
      @(posedge clk);
      if (txe_q.size() == 0) break;
    end
    if (n == 300) give_up;
  endtask
  always @(posedge clk) begin
    if (psel && pen && pready === 1'b1) begin
      chk("apb", exp_q.pop_front(), {pslverr, pwr ? 32'h0 : prdata});
    end
    if (tx_c.valid === 1'b1 && tx_ready === 1'b1) begin
      chk("tx byte", txe_q.pop_front(), tx_c.data);
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    chk("rts_n", 1'b1, rts_n);
    apb(1'b0, 8'h08, 32'h0, 33'h001);
    apb(1'b0, 8'h24, 32'h0, 33'h200);
    apb(1'b0, 8'h30, 32'h0, 33'h1_0000_0000);
    apb(1'b0, 8'h09, 32'h0, 33'h1_0000_0001);
    wr(8'h0c, 8'hbf);
    apb(1'b0, 8'h08, 32'h0, 33'h0);
    wr(8'h0c, 8'h00);
    for (int s = 0; s < 4; s++) begin
      wr(8'h08, {s[1:0], 6'h03});
      repeat (rxl[s] - 1) peer.send(8'h41);
      repeat (3) @(posedge clk);
      chk("rx trigger", 1'b0, rxt);
      peer.send(8'h41);
      repeat (3) @(posedge clk);
      chk("rx trigger", 1'b1, rxt);
    end
    repeat (8) peer.send(8'h41);
    apb(1'b0, 8'h24, 32'h0, 33'h0040_0600);
    wr(8'h08, 8'hc3);
    apb(1'b0, 8'h24, 32'h0, 33'h200);
    enh(8'h1c, 8'h13);
    enh(8'h14, 8'h11);
    enh(8'h08, 8'h20);
    peer.send(8'h13);
    apb(1'b0, 8'h24, 32'h0, 33'h0001_0200);
    apb(1'b0, 8'h08, 32'h0, 33'h0d0);
    apb(1'b0, 8'h08, 32'h0, 33'h0c1);
    enh(8'h08, 8'h21);
    peer.send(8'h13);
    apb(1'b0, 8'h24, 32'h0, 33'h0001_0300);
    apb(1'b0, 8'h08, 32'h0, 33'h0d0);
    peer.send(8'h11);
    apb(1'b0, 8'h24, 32'h0, 33'h0001_0200);
    wr(8'h08, 8'h03);
    wr(8'h10, 8'h02);
    repeat (2) @(posedge clk);
    chk("rts_n", 1'b0, rts_n);
    enh(8'h08, 8'h40);
    repeat (8) peer.send(8'h41);
    repeat (3) @(posedge clk);
    chk("rts_n", 1'b1, rts_n);
    txe_q = '{33'h13, 33'h11};
    enh(8'h08, 8'h44);
    wr(8'h08, 8'h03);
    drain;
    for (int k = 0; k < 2; k++) begin
      enh(8'h08, k ? 8'h00 : 8'h80);
      hold <= k[0] ? 1'($random(seed)) : 1'b1;
      repeat (3) begin
        b = 8'($random(seed));
        txe_q.push_back({25'h0, b});
        wr(8'h00, b);
      end
      repeat (10) @(posedge clk);
      if (k == 0) chk("tx valid", 1'b0, tx_c.valid);
      slow <= 1'($random(seed));
      hold <= k[0];
      drain;
    end
    enh(8'h08, 8'h80);
    wr(8'h08, 8'h25);
    repeat (34) wr(8'h00, 8'h5a);
    repeat (3) @(posedge clk);
    chk("tx trigger", 1'b1, txt);
    enh(8'h08, 8'h90);
    wr(8'h08, 8'h25);
    repeat (32) wr(8'h00, 8'h5a);
    repeat (3) @(posedge clk);
    chk("tx trigger", 1'b1, txt);
    repeat (2) wr(8'h00, 8'h5a);
    repeat (3) @(posedge clk);
    chk("tx trigger", 1'b0, txt);
    final_report;
  end
endmodule
